// >>> rtl/wfp_defines.vh
// register map, reset values and frame layout of the waveform engine
`ifndef WFP_DEFINES_VH
`define WFP_DEFINES_VH

// ==========================================================
// register offsets
`define WFP_ADDR_SRC       7'h00
`define WFP_ADDR_PMODE     7'h02
`define WFP_ADDR_REARM     7'h03
`define WFP_ADDR_PLEN      7'h04
`define WFP_ADDR_MON_A     7'h08
`define WFP_ADDR_MON_E     7'h0C
`define WFP_ADDR_HOLD      7'h0D
`define WFP_ADDR_FLAGS     7'h0E
`define WFP_ADDR_MEM_BASE  7'h10
`define WFP_ADDR_MEM_LAST  7'h2F

// ==========================================================
// field positions
`define WFP_BIT_SRC        0
`define WFP_BIT_PMODE      0
`define WFP_BIT_REARM      0
`define WFP_MON_ARM_BIT    7
`define WFP_MON_THR_MSB    6
`define WFP_HI_CODE_MSB    5

// ==========================================================
// reset values
`define WFP_RST_CTRL       1'b0
`define WFP_RST_PLEN       4'h3
`define WFP_RST_MON        8'h00
`define WFP_RST_FLAGS      5'h00
`define WFP_RST_HOLD       5'h00
`define WFP_RST_LVL_0      14'h1000
`define WFP_RST_LVL_1      14'h2000
`define WFP_RST_LVL_2      14'h3000
`define WFP_RST_LVL_3      14'h2000
`define WFP_RST_LVL_MID    14'h2000

// ==========================================================
// serial frame: read flag, 7-bit address, 8-bit data, msb first
`define WFP_SPI_BITS       5'h10
`define WFP_SPI_HDR_LAST   5'h07
`define WFP_SPI_LAST       5'h0F
`define WFP_SPI_TX_FIRST   5'h09

`endif

// >>> rtl/wfp_sync.v
// two-flop synchroniser with edge detection for pins from other domains
module wfp_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst_n,
	// pins
	input  wire [WIDTH-1:0] async_in,
	// synchronised view
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] rise,
	output wire [WIDTH-1:0] fall
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;
	reg [WIDTH-1:0] prev_q;

	// ==========================================================
	// capture chain; meta_q feeds sync_q only
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
			prev_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;

endmodule

// >>> rtl/wfp_core.v
// waveform engine: pattern/streaming source, fault monitors, shutdown latch
//
// Notes on behaviour
// - pattern mode: strobe rise loads level, strobe fall updates driver
// - pattern memory holds up to 16 levels played back in order
// - each level uses low byte bits 7..0, high byte bits 13..8
// - level k lives at byte 2k (low) and 2k+1 (high) of memory
// - memory resets to a four-step up-down staircase, host may rewrite
// - after reset the engine streams codes from the parallel pins
// - streaming: code latched on strobe rise, driver updated on fall
// - all protection is off after reset until the host arms it
// - five monitor registers hold 7-bit thresholds in bits 6..0
// - bit 7 arms a monitor; only armed alarms force shutdown
// - flag is set while armed fault exists, drops when it clears
// - writing 1 to a flag bit clears it, 0 leaves it
// - fault shutdown persists after the fault goes, until re-enabled
// - hold bits keep a triggered flag set; writing 0 releases
// - monitors act independently; any armed one triggers shutdown
// - alarm latches shutdown pin high until fault clear and re-enabled
// - re-enable by rearm bit high-low, clear pulse, or pin low-float
// - pointer steps on strobe fall, wraps after the final level
// - driver is disabled whenever the shutdown pin is high
`include "wfp_defines.vh"

module wfp_core #(
	parameter LEVELS = 16,
	parameter PTR_W  = 4,
	parameter CODE_W = 14,
	parameter MONS   = 5
) (
	// system
	input  wire              CLK_SYS,
	input  wire              RESET_N,
	// serial register port
	input  wire              SPI_SCLK,
	input  wire              SPI_CS_N,
	input  wire              SPI_MOSI,
	output wire              SPI_MISO,
	output wire              SPI_MISO_OE,
	// sample strobe and parallel code pins
	input  wire              SYNC_STROBE,
	input  wire [CODE_W-1:0] DB_I,
	output wire [CODE_W-1:0] DB_O,
	output wire              DB_OE,
	// converter side
	output wire [CODE_W-1:0] DAC_CODE,
	output wire              DRV_UPDATE,
	// fault monitors
	input  wire [MONS-1:0]   FAULT_DET,
	output wire [6:0]        MON_THR_A,
	output wire [6:0]        MON_THR_B,
	output wire [6:0]        MON_THR_C,
	output wire [6:0]        MON_THR_D,
	output wire [6:0]        MON_THR_E,
	// shutdown
	input  wire              SDN_CLEAR,
	input  wire              SDN_PIN_I,
	output wire              SDN_PIN_O,
	output wire              SDN_PIN_OE,
	output wire              DRIVER_EN
);

	// ==========================================================
	// pin synchronisers
	wire [5:0]        pin_lvl;
	wire [5:0]        pin_rise;
	wire [5:0]        pin_fall;
	wire [CODE_W-1:0] db_lvl;
	wire [MONS-1:0]   fault_lvl;

	wfp_sync #(.WIDTH(6)) u_sync_ctl (
		.clk      (CLK_SYS),
		.rst_n    (RESET_N),
		.async_in ({SDN_PIN_I, SDN_CLEAR, SYNC_STROBE,
		            SPI_MOSI, SPI_CS_N, SPI_SCLK}),
		.level    (pin_lvl),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	// data bits are only used at a strobe edge, after they have settled
	wfp_sync #(.WIDTH(CODE_W)) u_sync_db (
		.clk      (CLK_SYS),
		.rst_n    (RESET_N),
		.async_in (DB_I),
		.level    (db_lvl),
		.rise     (),
		.fall     ()
	);

	wfp_sync #(.WIDTH(MONS)) u_sync_flt (
		.clk      (CLK_SYS),
		.rst_n    (RESET_N),
		.async_in (FAULT_DET),
		.level    (fault_lvl),
		.rise     (),
		.fall     ()
	);

	wire sclk_rise = pin_rise[0];
	wire sclk_fall = pin_fall[0];
	wire cs_high   = pin_lvl[1];
	wire mosi_s    = pin_lvl[2];
	wire sync_rise = pin_rise[3];
	wire sync_fall = pin_fall[3];
	wire clr_fall  = pin_fall[4];
	wire pin_high  = pin_lvl[5];

	// ==========================================================
	// register state
	reg              src_q;
	reg              pmode_q;
	reg              rearm_q;
	reg              rearm_prev_q;
	reg [PTR_W-1:0]  plen_q;
	reg [7:0]        mon_q    [0:MONS-1];
	reg [MONS-1:0]   hold_q;
	reg [MONS-1:0]   flag_q;
	reg [7:0]        mem_lo_q [0:LEVELS-1];
	reg [5:0]        mem_hi_q [0:LEVELS-1];

	// ==========================================================
	// serial slave, mode 0, 16-bit frames
	reg  [4:0]  bit_cnt_q;
	reg  [15:0] rx_q;
	reg  [7:0]  tx_q;
	reg  [7:0]  rd_data;
	wire [6:0]  hdr_addr = {rx_q[5:0], mosi_s};
	wire [6:0]  wr_addr  = rx_q[13:7];
	wire [7:0]  wr_data  = {rx_q[6:0], mosi_s};
	wire        wr_en    = !cs_high && sclk_rise &&
	                       bit_cnt_q == `WFP_SPI_LAST && !rx_q[14];
	wire [6:0]  mem_off  = hdr_addr - `WFP_ADDR_MEM_BASE;
	wire [6:0]  wmem_off = wr_addr - `WFP_ADDR_MEM_BASE;
	wire        wr_mem   = wr_en && wr_addr >= `WFP_ADDR_MEM_BASE &&
	                       wr_addr <= `WFP_ADDR_MEM_LAST;

	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			bit_cnt_q <= 5'h00;
			rx_q      <= 16'h0000;
			tx_q      <= 8'h00;
		end else if (cs_high) begin
			bit_cnt_q <= 5'h00;
		end else if (sclk_rise && bit_cnt_q < `WFP_SPI_BITS) begin
			rx_q      <= {rx_q[14:0], mosi_s};
			bit_cnt_q <= bit_cnt_q + 5'h01;
			// read data fetched as soon as the address is complete
			if (bit_cnt_q == `WFP_SPI_HDR_LAST)
				tx_q <= rd_data;
		end else if (sclk_fall && bit_cnt_q >= `WFP_SPI_TX_FIRST) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign SPI_MISO    = tx_q[7];
	assign SPI_MISO_OE = !cs_high;

	// ==========================================================
	// read decode; reserved and unmapped bits read zero
	integer r;
	always @* begin
		rd_data = 8'h00;
		if (hdr_addr >= `WFP_ADDR_MEM_BASE &&
		    hdr_addr <= `WFP_ADDR_MEM_LAST) begin
			if (mem_off[0])
				rd_data = {2'b00, mem_hi_q[mem_off[4:1]]};
			else
				rd_data = mem_lo_q[mem_off[4:1]];
		end else begin
			for (r = 0; r < MONS; r = r + 1) begin
				if (hdr_addr == `WFP_ADDR_MON_A + r[6:0])
					rd_data = mon_q[r];
			end
			case (hdr_addr)
				`WFP_ADDR_SRC:   rd_data = {7'h00, src_q};
				`WFP_ADDR_PMODE: rd_data = {7'h00, pmode_q};
				`WFP_ADDR_REARM: rd_data = {7'h00, rearm_q};
				`WFP_ADDR_PLEN:  rd_data = {4'h0, plen_q};
				`WFP_ADDR_HOLD:  rd_data = {3'h0, hold_q};
				`WFP_ADDR_FLAGS: rd_data = {3'h0, flag_q};
				default:         rd_data = rd_data;
			endcase
		end
	end

	// ==========================================================
	// control and monitor registers
	integer m;
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			src_q   <= `WFP_RST_CTRL;
			pmode_q <= `WFP_RST_CTRL;
			rearm_q <= `WFP_RST_CTRL;
			plen_q  <= `WFP_RST_PLEN;
			hold_q  <= `WFP_RST_HOLD;
			for (m = 0; m < MONS; m = m + 1)
				mon_q[m] <= `WFP_RST_MON;
		end else if (wr_en) begin
			case (wr_addr)
				`WFP_ADDR_SRC:   src_q   <= wr_data[`WFP_BIT_SRC];
				`WFP_ADDR_PMODE: pmode_q <= wr_data[`WFP_BIT_PMODE];
				`WFP_ADDR_REARM: rearm_q <= wr_data[`WFP_BIT_REARM];
				`WFP_ADDR_PLEN:  plen_q  <= wr_data[PTR_W-1:0];
				`WFP_ADDR_HOLD:  hold_q  <= wr_data[MONS-1:0];
				default:         plen_q  <= plen_q;
			endcase
			for (m = 0; m < MONS; m = m + 1) begin
				if (wr_addr == `WFP_ADDR_MON_A + m[6:0])
					mon_q[m] <= wr_data;
			end
		end
	end

	// ==========================================================
	// pattern memory, reset to the staircase
	localparam [13:0] RST_MID = `WFP_RST_LVL_MID;
	localparam [13:0] RST_L0  = `WFP_RST_LVL_0;
	localparam [13:0] RST_L1  = `WFP_RST_LVL_1;
	localparam [13:0] RST_L2  = `WFP_RST_LVL_2;
	localparam [13:0] RST_L3  = `WFP_RST_LVL_3;
	integer k;
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			for (k = 0; k < LEVELS; k = k + 1) begin
				mem_lo_q[k] <= RST_MID[7:0];
				mem_hi_q[k] <= RST_MID[13:8];
			end
			mem_lo_q[0] <= RST_L0[7:0];
			mem_hi_q[0] <= RST_L0[13:8];
			mem_lo_q[1] <= RST_L1[7:0];
			mem_hi_q[1] <= RST_L1[13:8];
			mem_lo_q[2] <= RST_L2[7:0];
			mem_hi_q[2] <= RST_L2[13:8];
			mem_lo_q[3] <= RST_L3[7:0];
			mem_hi_q[3] <= RST_L3[13:8];
		end else if (wr_mem) begin
			if (wmem_off[0])
				mem_hi_q[wmem_off[4:1]] <= wr_data[`WFP_HI_CODE_MSB:0];
			else
				mem_lo_q[wmem_off[4:1]] <= wr_data;
		end
	end

	// ==========================================================
	// strobe engine
	// both bits must be set; a half-set pair keeps streaming
	wire              pat_mode = src_q & pmode_q;
	reg  [PTR_W-1:0]  ptr_q;
	reg  [CODE_W-1:0] code_q;
	reg  [CODE_W-1:0] db_o_q;
	reg               upd_q;
	wire [CODE_W-1:0] cur_level = {mem_hi_q[ptr_q], mem_lo_q[ptr_q]};

	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			ptr_q  <= {PTR_W{1'b0}};
			code_q <= {CODE_W{1'b0}};
			db_o_q <= {CODE_W{1'b0}};
			upd_q  <= 1'b0;
		end else begin
			upd_q  <= sync_fall;
			db_o_q <= cur_level;
			if (sync_rise) begin
				if (pat_mode)
					code_q <= cur_level;
				else
					code_q <= db_lvl;
			end
			if (!pat_mode)
				ptr_q <= {PTR_W{1'b0}};
			else if (sync_fall) begin
				if (ptr_q >= plen_q)
					ptr_q <= {PTR_W{1'b0}};
				else
					ptr_q <= ptr_q + 1'b1;
			end
		end
	end

	assign DAC_CODE   = code_q;
	assign DRV_UPDATE = upd_q;
	// pins carry the live pattern level while the host floats them
	assign DB_O       = db_o_q;
	assign DB_OE      = pat_mode;

	// ==========================================================
	// fault flags
	reg  [MONS-1:0] arm;
	wire [MONS-1:0] alarm_set;
	wire [MONS-1:0] flag_clr;

	// own loop index; m belongs to the clocked register process
	integer n;
	always @* begin
		for (n = 0; n < MONS; n = n + 1)
			arm[n] = mon_q[n][`WFP_MON_ARM_BIT];
	end

	assign alarm_set = arm & fault_lvl;
	assign flag_clr  = (wr_en && wr_addr == `WFP_ADDR_FLAGS) ?
	                   wr_data[MONS-1:0] : {MONS{1'b0}};

	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N)
			flag_q <= `WFP_RST_FLAGS;
		else
			// set wins over a clear in the same cycle
			flag_q <= alarm_set | (flag_q & hold_q & ~flag_clr);
	end

	// ==========================================================
	// shutdown latch
	reg  sdn_q;
	reg  drive_seen_q;
	reg  drv_en_q;
	wire rearm_fall   = rearm_prev_q & ~rearm_q;
	wire pin_override = drive_seen_q & ~pin_high;
	wire reenable     = rearm_fall | clr_fall | pin_override;

	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			sdn_q        <= 1'b0;
			drive_seen_q <= 1'b0;
			rearm_prev_q <= 1'b0;
			drv_en_q     <= 1'b0;
		end else begin
			rearm_prev_q <= rearm_q;
			// an alarm still present beats any re-enable
			if (|alarm_set)
				sdn_q <= 1'b1;
			else if (reenable)
				sdn_q <= 1'b0;
			// own drive must be seen high first, else sync lag looks low
			if (!sdn_q)
				drive_seen_q <= 1'b0;
			else if (pin_high)
				drive_seen_q <= 1'b1;
			drv_en_q <= ~sdn_q & ~pin_high;
		end
	end

	assign SDN_PIN_O  = 1'b1;
	assign SDN_PIN_OE = sdn_q;
	assign DRIVER_EN  = drv_en_q;

	// ==========================================================
	// thresholds to the analog comparators
	assign MON_THR_A = mon_q[0][`WFP_MON_THR_MSB:0];
	assign MON_THR_B = mon_q[1][`WFP_MON_THR_MSB:0];
	assign MON_THR_C = mon_q[2][`WFP_MON_THR_MSB:0];
	assign MON_THR_D = mon_q[3][`WFP_MON_THR_MSB:0];
	assign MON_THR_E = mon_q[4][`WFP_MON_THR_MSB:0];

endmodule

// >>> verif/wfp_fpga_model.sv
// fpga stand-in: parallel codes and the sample strobe
module wfp_fpga_model (
	// clock
	input wire logic    clk,
	// high while the device drives the code pins
	input wire logic    float_db,
	// strobe and codes
	output logic        strobe,
	output logic [13:0] db
);
	timeunit 1ns;
	timeprecision 1ps;
	initial strobe = 1'b0;
	initial db = 14'h0000;
	// =====
	// one 80 ns strobe period; strobe idles low between calls
	task step(input logic [13:0] c);
		@(posedge clk);
		db <= float_db ? ~db : c;
		repeat (3) @(posedge clk);
		strobe <= 1'b1;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
	endtask
endmodule

// >>> verif/wfp_core_asserts.sv
// port checker for the waveform engine, bound into the core
module wfp_core_asserts #(
	parameter CODE_W = 14,
	parameter MONS   = 5
) (
	// clock, reset, register port
	input wire logic              CLK_SYS,
	input wire logic              RESET_N,
	input wire logic              SPI_CS_N,
	// strobe and codes
	input wire logic              SYNC_STROBE,
	input wire logic [CODE_W-1:0] DB_I,
	input wire logic [CODE_W-1:0] DB_O,
	input wire logic              DB_OE,
	input wire logic [CODE_W-1:0] DAC_CODE,
	input wire logic              DRV_UPDATE,
	// faults and shutdown
	input wire logic [MONS-1:0]   FAULT_DET,
	input wire logic              SDN_CLEAR,
	input wire logic              SDN_PIN_I,
	input wire logic              SDN_PIN_OE,
	input wire logic              DRIVER_EN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	// =====
	// cycles since any re-enable cause; the syncs need a few
	logic [3:0] quiet_q;
	logic [3:0] quiet_d;
	always @* begin
		quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
		if (!SPI_CS_N || SDN_CLEAR || !SDN_PIN_I) quiet_d = 4'h0;
	end
	always @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) quiet_q <= 4'h0;
		else quiet_q <= quiet_d;
	end
	// =====
	// strobe steps
	sequence s_fall;
		$fell(SYNC_STROBE);
	endsequence
	sequence s_rise_stream;
		$rose(SYNC_STROBE) && !DB_OE;
	endsequence
	a_update_pulse: assert property (DRV_UPDATE |=> !DRV_UPDATE)
		else $error("driver update wider than one cycle");
	a_update_fall: assert property (s_fall |-> ##[2:5] DRV_UPDATE)
		else $error("no driver update after strobe fall");
	a_stream_latch: assert property (s_rise_stream |-> ##4 DAC_CODE == DB_I)
		else $error("streamed code not latched");
	a_pattern_load: assert property ($rose(SYNC_STROBE) && DB_OE |-> ##4 DAC_CODE == DB_O)
		else $error("pattern level not loaded");
	a_code_stands: assert property ($changed(DAC_CODE) |-> $past(SYNC_STROBE, 2))
		else $error("converter code moved without strobe");
	a_shut_holds: assert property (SDN_PIN_OE && quiet_q > 4'h5 |=> SDN_PIN_OE)
		else $error("shutdown dropped without re-enable");
	a_driver_off: assert property (SDN_PIN_OE |=> !DRIVER_EN)
		else $error("driver on during shutdown");
	a_trip_cause: assert property ($rose(SDN_PIN_OE) |-> |$past(FAULT_DET, 3))
		else $error("shutdown without fault");
	a_mode_by_spi: assert property ($changed(DB_OE) |-> !$past(SPI_CS_N))
		else $error("mode changed outside a frame");
endmodule

bind wfp_core wfp_core_asserts #(.CODE_W(CODE_W), .MONS(MONS)) u_chk (
	.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .SPI_CS_N(SPI_CS_N),
	.SYNC_STROBE(SYNC_STROBE), .DB_I(DB_I), .DB_O(DB_O), .DB_OE(DB_OE),
	.DAC_CODE(DAC_CODE), .DRV_UPDATE(DRV_UPDATE), .FAULT_DET(FAULT_DET),
	.SDN_CLEAR(SDN_CLEAR), .SDN_PIN_I(SDN_PIN_I), .SDN_PIN_OE(SDN_PIN_OE),
	.DRIVER_EN(DRIVER_EN)
);

// >>> verif/wfp_core_tb_top.sv
// self-checking bench for the waveform engine
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end

module wfp_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// =====
	// pins and counters
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sclk = 1'b0;
	logic        cs_n = 1'b1;
	logic        mosi = 1'b0;
	logic        clr = 1'b0;
	logic        pull_lo = 1'b0;
	logic [4:0]  fault = 5'h00;
	wire         miso, miso_oe, strobe, db_oe, upd, sdn_oe, sdn_o, drv_en;
	wire  [6:0]  thr_a, thr_b, thr_c, thr_d, thr_e;
	wire  [13:0] db_fpga, db_o, code;
	wire  [13:0] db = db_oe ? db_o : db_fpga;
	// floating pin reads low; pulling low beats the device
	wire         sdn = !pull_lo && sdn_oe && sdn_o;
	int          mismatches = 0;
	int          n_tests = 0;
	int          n_upd = 0;
	logic [13:0] lvl [16];
	logic [13:0] sc [4];
	always #5 clk = ~clk;
	always @(posedge clk) if (upd === 1'b1) n_upd++;
	wfp_core dut (
		.CLK_SYS(clk), .RESET_N(rst_n), .SPI_SCLK(sclk), .SPI_CS_N(cs_n),
		.SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe),
		.SYNC_STROBE(strobe), .DB_I(db), .DB_O(db_o), .DB_OE(db_oe),
		.DAC_CODE(code), .DRV_UPDATE(upd), .FAULT_DET(fault),
		.MON_THR_A(thr_a), .MON_THR_B(thr_b), .MON_THR_C(thr_c),
		.MON_THR_D(thr_d), .MON_THR_E(thr_e), .SDN_CLEAR(clr),
		.SDN_PIN_I(sdn), .SDN_PIN_O(sdn_o),
		.SDN_PIN_OE(sdn_oe), .DRIVER_EN(drv_en)
	);
	wfp_fpga_model fpga (.clk(clk), .float_db(db_oe), .strobe(strobe),
		.db(db_fpga));
	// =====
	// register port: halves of 5 clocks, data moved while clock low
	task spi(input logic rd, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {rd, a, d};
		q = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		mosi <= f[15];
		for (int i = 0; i < 16; i++) begin
			repeat (5) @(posedge clk);
			if (i > 7) q = {q[6:0], miso};
			sclk <= 1'b1;
			repeat (5) @(posedge clk);
			sclk <= 1'b0;
			mosi <= f[(14 - i) & 15];
		end
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		spi(1'b0, a, d, q);
	endtask
	task rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		spi(1'b1, a, 8'h00, q);
		`CHK("register", e, q)
	endtask
	task play(input int n, input int m);
		for (int k = 0; k < n; k++) begin
			fpga.step(14'h0000);
			`CHK("level", lvl[k % m], code)
		end
	endtask
	task trip(input logic [4:0] f);
		@(posedge clk);
		fault <= f;
		repeat (10) @(posedge clk);
		`CHK("sdn_oe", 1'b1, sdn_oe)
		`CHK("drv_en", 1'b0, drv_en)
		rd(7'h0E, {3'b000, f});
		fault <= 5'h00;
		repeat (10) @(posedge clk);
		`CHK("sdn_oe", 1'b1, sdn_oe)
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400us;
		mismatches++;
		tally_and_finish;
	end
	// =====
	// scenarios
	initial begin
		lvl = '{0: 14'h1000, 1: 14'h2000, 2: 14'h3000, default: 14'h2000};
		// edge to full scale in n = 3 steps of floor(2^14 / 3) codes
		sc = '{14'h0000, 14'h1555, 14'h2AAA, 14'h3FFF};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("drv_en", 1'b1, drv_en)
		`CHK("db_oe", 1'b0, db_oe)
		`CHK("miso_oe", 1'b0, miso_oe)
		`CHK("thresholds", 35'h0, {thr_a, thr_b, thr_c, thr_d, thr_e})
		rd(7'h0D, 8'h00);
		rd(7'h0E, 8'h00);
		rd(7'h08, 8'h00);
		rd(7'h30, 8'h00);
		for (int k = 0; k < 4; k++) begin
			rd(7'h10 + 7'(2 * k), lvl[k][7:0]);
			rd(7'h11 + 7'(2 * k), {2'b00, lvl[k][13:8]});
		end
		fault <= 5'h1F;
		repeat (10) @(posedge clk);
		`CHK("sdn_oe", 1'b0, sdn_oe)
		fault <= 5'h00;
		for (int k = 0; k < 4; k++) begin
			fpga.step(sc[k]);
			`CHK("stream", sc[k], code)
		end
		repeat (6) @(posedge clk);
		`CHK("updates", 4, n_upd)
		wr(7'h02, 8'h01);
		`CHK("db_oe", 1'b0, db_oe)
		wr(7'h00, 8'h01);
		`CHK("db_oe", 1'b1, db_oe)
		wr(7'h12, 8'hFF);
		wr(7'h13, 8'hFF);
		rd(7'h13, 8'h3F);
		lvl[1] = 14'h3FFF;
		play(6, 4);
		wr(7'h00, 8'h00);
		wr(7'h04, 8'h0F);
		wr(7'h2E, 8'hBC);
		wr(7'h2F, 8'h0A);
		lvl[15] = 14'h0ABC;
		wr(7'h00, 8'h01);
		play(17, 16);
		wr(7'h00, 8'h00);
		wr(7'h02, 8'h00);
		`CHK("db_oe", 1'b0, db_oe)
		wr(7'h0A, 8'h14);
		wr(7'h0A, 8'h94);
		`CHK("threshold", 7'h14, thr_c)
		rd(7'h0A, 8'h94);
		trip(5'h04);
		rd(7'h0E, 8'h00);
		wr(7'h03, 8'h01);
		`CHK("sdn_oe", 1'b1, sdn_oe)
		wr(7'h03, 8'h00);
		`CHK("sdn_oe", 1'b0, sdn_oe)
		wr(7'h0D, 8'h04);
		trip(5'h04);
		rd(7'h0E, 8'h04);
		wr(7'h0E, 8'h00);
		rd(7'h0E, 8'h04);
		wr(7'h0E, 8'h04);
		rd(7'h0E, 8'h00);
		clr <= 1'b1;
		repeat (5) @(posedge clk);
		clr <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("sdn_oe", 1'b0, sdn_oe)
		wr(7'h0D, 8'h00);
		wr(7'h0C, 8'h1C);
		wr(7'h0C, 8'h9C);
		`CHK("threshold", 7'h1C, thr_e)
		trip(5'h10);
		pull_lo <= 1'b1;
		repeat (6) @(posedge clk);
		pull_lo <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("sdn_oe", 1'b0, sdn_oe)
		`CHK("drv_en", 1'b1, drv_en)
		tally_and_finish;
	end
endmodule
